/* File: pkg/crs_pkg.sv */
// Operation
// - sixty-four kilobyte address space, sixteen-bit addresses
// - sixteen-bit instruction pointer tracks fetch location
// - sixteen-bit accumulator, byte ops use low byte
// - sixteen-bit temporary accumulator is second operand
// - index register offsets indexed effective addresses
// - sixteen-bit extra pointer addresses memory
// - sixteen-bit stack pointer locates stack area
// - status word: bank/page upper, condition codes lower
// - bank pointer picks active general register bank
// - direct addresses 0x80-0xFF remap through page select
// - direct addresses 0x00-0x7F pass through unchanged
// - page 0 maps 0x0080, others step 128 bytes
// - half-carry follows carry or borrow from bit 3
// - interrupt enable gates interrupts, cleared by reset
// - interrupt taken only when level beats mask
// - negative flag copies result sign bit
// - zero flag set on zero result
// - overflow flag set on two's-complement overflow
// - carry from bit 7, shifts load shifted-out bit
// - eight-bit general registers, eight per bank, 32 banks
// - low three opcode bits select bank register
package crs_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] CRS_OFF_IP = 8'h00;
   localparam logic [7:0] CRS_OFF_ACC = 8'h04;
   localparam logic [7:0] CRS_OFF_TMP = 8'h08;
   localparam logic [7:0] CRS_OFF_IDX = 8'h0C;
   localparam logic [7:0] CRS_OFF_EP = 8'h10;
   localparam logic [7:0] CRS_OFF_SP = 8'h14;
   localparam logic [7:0] CRS_OFF_PSW = 8'h18;
   localparam logic [7:0] CRS_OFF_STAT = 8'h1C;
   // reset values
   localparam logic [15:0] CRS_RST_REG = 16'h0000;
   localparam logic [15:0] CRS_RST_PSW = 16'h0030;
   // address map constants
   localparam logic [15:0] CRS_BANK_BASE = 16'h0100;
   localparam logic [15:0] CRS_PAGE_BASE = 16'h0080;
   // status word layout, upper byte then condition code byte
   typedef struct packed {
      logic [4:0] bank_select_pointer;
      logic [2:0] direct_page_select;
      logic h;
      logic i;
      logic [1:0] int_level_mask;
      logic n;
      logic z;
      logic v;
      logic c;
   } crs_psw_t;
   // byte operations issued by the core
   typedef enum logic [2:0] {
      CRS_OP_NONE,
      CRS_OP_ADD,
      CRS_OP_SUB,
      CRS_OP_SHL,
      CRS_OP_SHR
   } crs_op_t;
   // captured bus address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic hit;
      logic [7:0] off;
   } crs_req_t;
endpackage

/* File: hdl/crs_register_set.sv */
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module crs_register_set
   import crs_pkg::*;
(
   input wire logic I_REF_CLK,
   input wire logic I_RESET,
   // ahb-lite slave
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   // core side, same clock
   input wire crs_op_t I_ALU_OP,
   input wire logic I_IP_STEP,
   input wire logic [2:0] I_REG_SEL,
   input wire logic [7:0] I_DIR_ADDR,
   input wire logic [7:0] I_IDX_DISP,
   input wire logic I_INT_REQ,
   input wire logic [1:0] I_INT_LEVEL,
   output logic [15:0] O_IP,
   output logic [15:0] O_ACC,
   output logic [15:0] O_TMP,
   output logic [15:0] O_IDX,
   output logic [15:0] O_EP,
   output logic [15:0] O_SP,
   output logic [15:0] O_PSW,
   output logic [15:0] O_GREG_ADDR,
   output logic [15:0] O_DIR_PHYS,
   output logic [15:0] O_EA_INDEXED,
   output logic O_INT_TAKE
);

   // dedicated registers
   logic [15:0] ip_q;
   logic [15:0] acc_q;
   logic [15:0] tmp_q;
   logic [15:0] idx_q;
   logic [15:0] ep_q;
   logic [15:0] sp_q;
   crs_psw_t psw_q;
   crs_psw_t psw_d;

   // bus pipeline
   crs_req_t req_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic hresp_q;
   logic addr_take;
   logic addr_hit;
   logic wr_en;
   logic [15:0] wdata;
   logic [31:0] rd_mux;

   // alu scratch
   logic [8:0] wide;
   logic [4:0] nib;
   logic [7:0] alu_res;
   logic alu_h;
   logic alu_v;
   logic alu_c;
   logic alu_go;
   logic alu_arith;
   logic [7:0] opa;
   logic [7:0] opb;

   // derived address outputs
   logic [15:0] greg_q;
   logic [15:0] dir_q;
   logic [15:0] ea_q;
   logic int_take_q;

   // a transfer is taken only when the bus is ready and the slot is ours
   assign addr_take = I_HSEL & I_HTRANS[1] & I_HREADY;
   // only word offsets inside the first 32 bytes decode
   assign addr_hit = (I_HADDR[31:5] == 27'h000_0000) &
                     (I_HADDR[1:0] == 2'b00);

   // capture the address phase, act on it in the data phase
   always_ff @(posedge I_REF_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         req_q <= '0;
      end
      else
      begin
         req_q.valid <= addr_take;
         req_q.write <= I_HWRITE;
         req_q.hit <= addr_hit;
         req_q.off <= I_HADDR[7:0];
      end
   end

   // registers are 16 bits, the upper half of the bus word is dropped
   assign wr_en = req_q.valid & req_q.write & req_q.hit;
   assign wdata = I_HWDATA[15:0];

   // read mux; a write in flight to the same word, except CRS_OFF_STAT, is forwarded so a
   // back-to-back write then read sees the new value
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (I_HADDR[7:0])
         CRS_OFF_IP: rd_mux = {16'h0000, ip_q};
         CRS_OFF_ACC: rd_mux = {16'h0000, acc_q};
         CRS_OFF_TMP: rd_mux = {16'h0000, tmp_q};
         CRS_OFF_IDX: rd_mux = {16'h0000, idx_q};
         CRS_OFF_EP: rd_mux = {16'h0000, ep_q};
         CRS_OFF_SP: rd_mux = {16'h0000, sp_q};
         CRS_OFF_PSW: rd_mux = {16'h0000, psw_q};
         CRS_OFF_STAT: rd_mux = {16'h0000, greg_q};
         default: rd_mux = 32'h0000_0000;
      endcase
      if (!addr_hit)
      begin
         rd_mux = 32'h0000_0000;
      end
      else if (wr_en && (req_q.off == I_HADDR[7:0]) &&
               (I_HADDR[7:0] != CRS_OFF_STAT))
      begin
         rd_mux = {16'h0000, wdata};
      end
   end

   // zero-wait slave: read data is loaded at the address edge and
   // stands through the data phase
   always_ff @(posedge I_REF_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         hrdata_q <= 32'h0000_0000;
         hreadyout_q <= 1'b0;
         hresp_q <= 1'b0;
      end
      else
      begin
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0; // always okay, unmapped reads zero
         if (addr_take && !I_HWRITE)
         begin
            hrdata_q <= rd_mux;
         end
      end
   end

   // operands are the low bytes of accumulator and temporary
   assign opa = acc_q[7:0];
   assign opb = tmp_q[7:0];
   assign alu_go = (I_ALU_OP != CRS_OP_NONE);
   assign alu_arith = (I_ALU_OP == CRS_OP_ADD) |
                      (I_ALU_OP == CRS_OP_SUB);

   // byte alu with flag generation
   always_comb
   begin
      wide = 9'h000;
      nib = 5'h00;
      alu_res = opa;
      alu_h = psw_q.h;
      alu_v = psw_q.v;
      alu_c = psw_q.c;
      case (I_ALU_OP)
         CRS_OP_ADD:
         begin
            wide = {1'b0, opa} + {1'b0, opb};
            nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
            alu_res = wide[7:0];
            alu_h = nib[4];
            alu_c = wide[8];
            alu_v = (opa[7] == opb[7]) & (wide[7] != opa[7]);
         end
         CRS_OP_SUB:
         begin
            wide = {1'b0, opa} - {1'b0, opb};
            nib = {1'b0, opa[3:0]} - {1'b0, opb[3:0]};
            alu_res = wide[7:0];
            alu_h = nib[4];
            alu_c = wide[8];
            alu_v = (opa[7] != opb[7]) & (wide[7] != opa[7]);
         end
         CRS_OP_SHL:
         begin
            alu_res = {opa[6:0], 1'b0};
            alu_c = opa[7];
         end
         CRS_OP_SHR:
         begin
            alu_res = {1'b0, opa[7:1]};
            alu_c = opa[0];
         end
         default:
         begin
            alu_res = opa;
         end
      endcase
   end

   // status word next value: flags from the alu win over a bus write
   // in the same cycle, so no result is ever lost
   always_comb
   begin
      psw_d = psw_q;
      if (wr_en && (req_q.off == CRS_OFF_PSW))
      begin
         psw_d = crs_psw_t'(wdata);
      end
      if (alu_go)
      begin
         psw_d.n = alu_res[7];
         psw_d.z = (alu_res == 8'h00);
         psw_d.c = alu_c;
         if (alu_arith)
         begin
            psw_d.h = alu_h;
            psw_d.v = alu_v;
         end
      end
   end

   // status word; reset leaves interrupts disabled, with mask 3 admitting levels 0 to 2
   always_ff @(posedge I_REF_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         psw_q <= crs_psw_t'(CRS_RST_PSW);
      end
      else
      begin
         psw_q <= psw_d;
      end
   end

   // instruction pointer; a bus load beats a fetch step
   always_ff @(posedge I_REF_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         ip_q <= CRS_RST_REG;
      end
      else if (wr_en && (req_q.off == CRS_OFF_IP))
      begin
         ip_q <= wdata;
      end
      else if (I_IP_STEP)
      begin
         ip_q <= ip_q + 16'h0001;
      end
   end

   // accumulator; byte results touch only the low byte
   always_ff @(posedge I_REF_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         acc_q <= CRS_RST_REG;
      end
      else if (alu_go)
      begin
         acc_q[7:0] <= alu_res;
      end
      else if (wr_en && (req_q.off == CRS_OFF_ACC))
      begin
         acc_q <= wdata;
      end
   end

   // pointer and data registers written only from the bus
   always_ff @(posedge I_REF_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         tmp_q <= CRS_RST_REG;
         idx_q <= CRS_RST_REG;
         ep_q <= CRS_RST_REG;
         sp_q <= CRS_RST_REG;
      end
      else if (wr_en)
      begin
         if (req_q.off == CRS_OFF_TMP)
         begin
            tmp_q <= wdata;
         end
         if (req_q.off == CRS_OFF_IDX)
         begin
            idx_q <= wdata;
         end
         if (req_q.off == CRS_OFF_EP)
         begin
            ep_q <= wdata;
         end
         if (req_q.off == CRS_OFF_SP)
         begin
            sp_q <= wdata;
         end
      end
   end

   // general register address: base plus bank times eight plus select;
   // five bank bits give 32 banks of eight byte registers
   always_ff @(posedge I_REF_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         greg_q <= CRS_BANK_BASE;
      end
      else
      begin
         greg_q <= CRS_BANK_BASE +
                   {8'h00, psw_q.bank_select_pointer, 3'h0} +
                   {13'h0000, I_REG_SEL};
      end
   end

   // direct page remap; the lower half never moves, the upper half
   // lands in a 128 byte window chosen by the page select
   always_ff @(posedge I_REF_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         dir_q <= CRS_RST_REG;
      end
      else if (!I_DIR_ADDR[7])
      begin
         dir_q <= {8'h00, I_DIR_ADDR};
      end
      else
      begin
         dir_q <= CRS_PAGE_BASE +
                  {6'h00, psw_q.direct_page_select, 7'h00} +
                  {9'h000, I_DIR_ADDR[6:0]};
      end
   end

   // indexed effective address, displacement is signed and the sum
   // wraps inside the 64 kbyte space
   always_ff @(posedge I_REF_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         ea_q <= CRS_RST_REG;
      end
      else
      begin
         ea_q <= idx_q + {{8{I_IDX_DISP[7]}}, I_IDX_DISP};
      end
   end

   // interrupt acceptance: enabled and strictly higher priority than
   // the mask; mask 0 therefore blocks every level
   always_ff @(posedge I_REF_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         int_take_q <= 1'b0;
      end
      else
      begin
         int_take_q <= I_INT_REQ & psw_q.i &
                       (I_INT_LEVEL < psw_q.int_level_mask);
      end
   end

   // outputs straight from flip-flops
   assign O_HRDATA = hrdata_q;
   assign O_HREADYOUT = hreadyout_q;
   assign O_HRESP = hresp_q;
   assign O_IP = ip_q;
   assign O_ACC = acc_q;
   assign O_TMP = tmp_q;
   assign O_IDX = idx_q;
   assign O_EP = ep_q;
   assign O_SP = sp_q;
   assign O_PSW = psw_q;
   assign O_GREG_ADDR = greg_q;
   assign O_DIR_PHYS = dir_q;
   assign O_EA_INDEXED = ea_q;
   assign O_INT_TAKE = int_take_q;

endmodule // crs_register_set

/* File: dv/crs_register_set_monitor.sv */
`timescale 1ns/1ps
module crs_chk
   import crs_pkg::*;
(
   input wire logic I_REF_CLK,
   input wire logic I_RESET,
   input wire crs_op_t I_ALU_OP,
   input wire logic [2:0] I_REG_SEL,
   input wire logic [7:0] I_DIR_ADDR,
   input wire logic [7:0] I_IDX_DISP,
   input wire logic I_INT_REQ,
   input wire logic [1:0] I_INT_LEVEL,
   input wire logic [15:0] O_ACC,
   input wire logic [15:0] O_IDX,
   input wire logic [15:0] O_PSW,
   input wire logic [15:0] O_GREG_ADDR,
   input wire logic [15:0] O_DIR_PHYS,
   input wire logic [15:0] O_EA_INDEXED,
   input wire logic O_INT_TAKE,
   input wire logic O_HRESP
);
   // all checks live in the one core clock domain
   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (I_RESET);
   // an alu step, then its flags seen one edge later
   sequence s_alu;
      I_ALU_OP != CRS_OP_NONE;
   endsequence
   property p_zero;
      s_alu |=> O_PSW[2] == (O_ACC[7:0] == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag off");
   property p_neg;
      s_alu |=> O_PSW[3] == O_ACC[7];
   endproperty
   a_neg: assert property (p_neg) else $error("sign flag off");
   // a left shift hands its old top bit to the carry
   property p_shl_c;
      I_ALU_OP == CRS_OP_SHL |=> O_PSW[0] == $past(O_ACC[7]);
   endproperty
   a_shl_c: assert property (p_shl_c) else $error("carry off");
   property p_int;
      1'b1 |=> O_INT_TAKE == ($past(I_INT_REQ) && $past(O_PSW[6])
         && ($past(I_INT_LEVEL) < $past(O_PSW[5:4])));
   endproperty
   a_int: assert property (p_int) else $error("irq take off");
   property p_greg;
      1'b1 |=> O_GREG_ADDR == 16'h0100 + {$past(O_PSW[15:11]), 3'h0}
         + $past(I_REG_SEL);
   endproperty
   a_greg: assert property (p_greg) else $error("bank addr off");
   property p_dir_lo;
      !I_DIR_ADDR[7] |=> O_DIR_PHYS == {9'h000, $past(I_DIR_ADDR[6:0])};
   endproperty
   a_dir_lo: assert property (p_dir_lo) else $error("low dir off");
   property p_dir_hi;
      I_DIR_ADDR[7] |=> O_DIR_PHYS == 16'h0080
         + {$past(O_PSW[10:8]), 7'h00} + $past(I_DIR_ADDR[6:0]);
   endproperty
   a_dir_hi: assert property (p_dir_hi) else $error("dir map off");
   property p_ea;
      1'b1 |=> O_EA_INDEXED == $past(O_IDX)
         + {{8{$past(I_IDX_DISP[7])}}, $past(I_IDX_DISP)};
   endproperty
   a_ea: assert property (p_ea) else $error("indexed ea off");
   property p_resp;
      !O_HRESP;
   endproperty
   a_resp: assert property (p_resp) else $error("bus error seen");
endmodule // crs_chk

bind crs_register_set crs_chk crs_chk_i (.I_REF_CLK, .I_RESET, .I_ALU_OP,
   .I_REG_SEL, .I_DIR_ADDR, .I_IDX_DISP, .I_INT_REQ, .I_INT_LEVEL, .O_ACC,
   .O_IDX, .O_PSW, .O_GREG_ADDR, .O_DIR_PHYS, .O_EA_INDEXED, .O_INT_TAKE,
   .O_HRESP);

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import crs_pkg::*;
   ;
   logic I_REF_CLK = 0, I_RESET = 1, I_HSEL = 1, I_HWRITE = 0;
   logic I_IP_STEP = 0, I_INT_REQ = 0, I_HREADY;
   logic [31:0] I_HADDR = '0, I_HWDATA = '0, O_HRDATA;
   logic [1:0] I_HTRANS = '0, I_INT_LEVEL = '0;
   logic [2:0] I_HSIZE = 3'h2, I_REG_SEL = '0;
   logic [7:0] I_DIR_ADDR = '0, I_IDX_DISP = '0;
   crs_op_t I_ALU_OP = CRS_OP_NONE;
   logic O_HREADYOUT, O_HRESP, O_INT_TAKE;
   logic [15:0] O_IP, O_ACC, O_TMP, O_IDX, O_EP, O_SP, O_PSW;
   logic [15:0] O_GREG_ADDR, O_DIR_PHYS, O_EA_INDEXED;
   int failures = 0, compares = 0;
   // single slave, so its ready is the bus ready
   assign I_HREADY = O_HREADYOUT;
   crs_register_set crs_register_set_i (.*);
   // 40 MHz core clock
   initial
   begin
      forever #12.5 I_REF_CLK = ~I_REF_CLK;
   end
   task end_sim;
      if (failures == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value at %0t: %h vs %h", $time, g, e);
      end
   endtask
   // one edge for registered outputs, then look at the settled value
   task tick;
      @(posedge I_REF_CLK);
      @(negedge I_REF_CLK);
   endtask
   // ready is read at the negedge so the registered value is not raced
   task wait_rdy(output logic [31:0] d);
      int n;
      logic r;
      n = 0;
      do
      begin
         @(negedge I_REF_CLK);
         r = O_HREADYOUT;
         d = O_HRDATA;
         @(posedge I_REF_CLK);
         n++;
      end
      while (r !== 1'b1 && n < 100);
      if (r !== 1'b1)
      begin
         failures++;
         end_sim;
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      logic [31:0] x;
      @(posedge I_REF_CLK);
      I_HADDR <= {24'h00_0000, a};
      I_HWRITE <= w;
      I_HTRANS <= 2'h2;
      wait_rdy(x);
      I_HTRANS <= 2'h0;
      I_HWDATA <= wd;
      wait_rdy(rd);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0000_0000, x);
      chk(x[31:16], 16'h0000);
      chk(x[15:0], e);
   endtask
   task t_regs;
      chk(O_PSW, 16'h0030);
      chk(O_GREG_ADDR, 16'h0100);
      for (int i = 0; i < 6; i++)
      begin
         wr(8'(i * 4), 32'hFFFF_A5C0 + i);
         rd(8'(i * 4), 16'hA5C0 + 16'(i));
      end
      rd(8'h40, 16'h0000);
      I_IP_STEP <= 1'b1;
      @(posedge I_REF_CLK);
      I_IP_STEP <= 1'b0;
      @(negedge I_REF_CLK);
      chk(O_IP, 16'hA5C1);
      // the register ports must show what the bus wrote
      chk(O_TMP, 16'hA5C2);
      chk(O_IDX, 16'hA5C3);
      chk(O_EP, 16'hA5C4);
      chk(O_SP, 16'hA5C5);
   endtask
   task t_map;
      wr(CRS_OFF_PSW, 32'h0000_F830);
      I_REG_SEL <= 3'h7;
      tick;
      chk(O_GREG_ADDR, 16'h01FF);
      wr(CRS_OFF_PSW, 32'h0000_0830);
      I_REG_SEL <= 3'h3;
      tick;
      chk(O_GREG_ADDR, 16'h010B);
      for (int p = 0; p < 8; p++)
      begin
         wr(CRS_OFF_PSW, {16'h0000, 5'h00, p[2:0], 8'h30});
         I_DIR_ADDR <= 8'h85;
         tick;
         chk(O_DIR_PHYS, 16'h0085 + 16'(p * 128));
      end
      @(posedge I_REF_CLK);
      I_DIR_ADDR <= 8'h12;
      tick;
      chk(O_DIR_PHYS, 16'h0012);
      wr(CRS_OFF_IDX, 32'h0000_1000);
      I_IDX_DISP <= 8'hF0;
      tick;
      chk(O_EA_INDEXED, 16'h0FF0);
   endtask
   // upper accumulator byte must survive every byte-wide step
   task alu(input crs_op_t op, input logic [7:0] a, input logic [7:0] t,
      input logic [7:0] r, input logic [4:0] f, input logic [4:0] m);
      wr(CRS_OFF_ACC, {16'h0000, 8'h5A, a});
      wr(CRS_OFF_TMP, {24'h00_0000, t});
      I_ALU_OP <= op;
      @(posedge I_REF_CLK);
      I_ALU_OP <= CRS_OP_NONE;
      @(negedge I_REF_CLK);
      chk(O_ACC, {8'h5A, r});
      chk({11'h000, O_PSW[7], O_PSW[3:0]} & m, {11'h000, f & m});
   endtask
   task t_alu;
      alu(CRS_OP_ADD, 8'h08, 8'h08, 8'h10, 5'h10, 5'h1F);
      alu(CRS_OP_ADD, 8'h7F, 8'h01, 8'h80, 5'h1A, 5'h1F);
      alu(CRS_OP_ADD, 8'h80, 8'h80, 8'h00, 5'h07, 5'h1F);
      alu(CRS_OP_SUB, 8'h10, 8'h01, 8'h0F, 5'h10, 5'h1F);
      alu(CRS_OP_SUB, 8'h00, 8'h01, 8'hFF, 5'h19, 5'h1F);
      alu(CRS_OP_SHL, 8'h81, 8'h00, 8'h02, 5'h01, 5'h0D);
      alu(CRS_OP_SHR, 8'h01, 8'h00, 8'h00, 5'h05, 5'h0D);
   endtask
   task t_int;
      wr(CRS_OFF_PSW, 32'h0000_0060);
      I_INT_REQ <= 1'b1;
      for (int l = 0; l < 4; l++)
      begin
         @(posedge I_REF_CLK);
         I_INT_LEVEL <= l[1:0];
         tick;
         chk({15'h0000, O_INT_TAKE}, 16'(l < 2));
      end
      wr(CRS_OFF_PSW, 32'h0000_0020);
      I_INT_LEVEL <= 2'h0;
      tick;
      chk({15'h0000, O_INT_TAKE}, 16'h0000);
   endtask
   initial
   begin
      repeat (2) @(posedge I_REF_CLK);
      I_RESET <= 1'b0;
      tick;
      t_regs;
      t_map;
      t_alu;
      t_int;
      end_sim;
   end
endmodule // tb_top
